// >>> common/t1_alarm_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz hclk, word-aligned register slots
// Notes: Offsets are register indexes; byte address is index * 4
`ifndef T1_ALARM_PARAMS_SVH
`define T1_ALARM_PARAMS_SVH

// -----------------------------------------------------------------
// Register indexes
// -----------------------------------------------------------------
`define IDX_BOM_RECEIVE_CONTROL 8'h2a
`define IDX_BOM_CODE_STATUS 8'h2b
`define IDX_ALARM_DETECT_CONFIG 8'h2c
`define IDX_ALARM_IRQ_ENABLE 8'h2d
`define IDX_ALARM_IRQ_STATUS 8'h2e
`define IDX_ALARM_RAW_STATUS 8'h2f

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define BIT_BOM_CODE_IRQ_EN 0
`define BIT_BOM_VAL_SEL 1
`define BIT_BOM_END_IRQ_EN 2
`define BIT_ESF 4
`define BIT_J1 5
`define BIT_FAST_CLEAR 4
`define BIT_ALL_ONES 0
`define BIT_CARRIER_FAIL 1
`define BIT_REMOTE 2
`define CHG_SHIFT 3

// -----------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------
`define BOM_NONE 6'h3f
`define HIST_EMPTY 7'h7f
`define HIST_YELLOW 7'h40
`define ESF_YEL_T1 16'hff00
`define ESF_YEL_J1 16'hffff

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 1000000
`define WIN_REMOTE_MS 40
`define WIN_ALL_ONES_MS 60
`define CF_SET_MS 2550
`define CF_CLR_MS 16600
`define CF_FAST_CLR_MS 120
`define AO_SET_MS 1500
`define AO_CLR_MS 16800
`define AO_FAST_CLR_MS 180
`define RA_SET_MS 425
`define RA_CLR_MS 425

// -----------------------------------------------------------------
// Thresholds
// -----------------------------------------------------------------
`define SF_T1_ONES_MAX 16
`define SF_J1_ZEROS_MAX 2
`define AO_ZEROS_LIMIT 127
`define VAL_LONG_N 10
`define VAL_LONG_K 8
`define VAL_SHORT_N 5
`define VAL_SHORT_K 4

`endif

// >>> common/t1_alarm_pkg.sv
// Purpose: Types for the alarm and message detector
// Assumes: Widths large enough for every count in the params header
// Notes: All module state lives in state_s
package t1_alarm_pkg;

   // --------------------------------------------------------------
   // Received stream strobe group
   // --------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic data;
      logic bit2;
      logic frame12_fbit;
      logic dl_bit;
      logic oof;
   } rx_stream_s;

   typedef logic [6:0] hist_entry_t;
   typedef logic [14:0] integ_cnt_t;

   // --------------------------------------------------------------
   // Whole module state
   // --------------------------------------------------------------
   typedef struct packed {
      logic bom_end_irq_en;
      logic bom_validation_select;
      logic bom_code_irq_en;
      logic japan_yellow_mode;
      logic esf;
      logic fast_alarm_clear;
      logic [2:0] irq_en;
      logic [5:0] bom_code;
      logic bom_end_flag;
      logic bom_code_flag;
      logic [2:0] chg;
      logic [2:0] alarm;
      logic oof_window_flag;
      logic remote_alarm_raw;
      logic all_ones_raw;
      logic [15:0] ms_cnt;
      logic [5:0] win40_cnt;
      logic [5:0] win60_cnt;
      logic oof_seen;
      logic [4:0] ones_cnt;
      logic [1:0] zeros12_cnt;
      logic oof_all;
      logic [6:0] zeros60_cnt;
      logic [15:0] dl_sr;
      logic [3:0] dl_cnt;
      hist_entry_t [9:0] hist;
      integ_cnt_t [2:0] integ;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] hrdata;
      logic irq_n;
   } state_s;

endpackage

// >>> hdl/t1_alarm_and_bom_detector.sv
// Purpose: Receive alarm detector and bit-oriented message receiver
// Assumes: Stream strobes synchronous to hclk, one bit per valid
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Operation
// - Accept BOM or ESF remote alarm on 8 of 10, or 4 of 5, matches.
// - Validated BOM code interrupts when its enable is set.
// - BOM present to absent interrupts when its enable is set.
// - BOM end sets end flag; status read clears it.
// - Validated BOM sets code flag; status read clears it.
// - Show received 6-bit code; all ones means no message.
// - Yellow mode bit picks T1 or J1 remote alarm recognition.
// - ESF select bit picks SF or ESF stream interpretation.
// - Carrier fail: set after 2.55 s, clear after 16.6 s or 120 ms.
// - All ones: set after 1.5 s, clear after 16.8 s or 180 ms.
// - Remote alarm state set and cleared after 425 ms steady.
// - Each alarm change flag interrupts only when enabled.
// - Alarm state edges set change flags; status read clears them.
// - Out-of-sync window flag reports any loss in latest 40 ms.
// - All ones when out of sync 60 ms with under 127 zeros.
// - T1 SF remote alarm when bit 2 is one at most 16 times.
// - J1 SF remote alarm when frame 12 F-bit zero at most twice.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps

`include "t1_alarm_params.svh"

module t1_alarm_and_bom_detector
   import t1_alarm_pkg::*;
#(
   parameter int MS_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire rx_stream_s rx,
   output logic irq_n
);

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function automatic logic [3:0] count_match(
      input hist_entry_t [9:0] h,
      input hist_entry_t val,
      input logic short_win
   );
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < `VAL_LONG_N; i++) begin
         if ((!short_win || i < `VAL_SHORT_N) && h[i] == val) begin
            n = n + 4'h1;
         end
      end
      return n;
   endfunction

   function automatic logic validated(
      input hist_entry_t [9:0] h,
      input hist_entry_t val,
      input logic short_win
   );
      logic [3:0] k;
      k = short_win ? 4'(`VAL_SHORT_K) : 4'(`VAL_LONG_K);
      return count_match(h, val, short_win) >= k;
   endfunction

   // Integrates raw against state; returns {toggle, next count}
   function automatic logic [15:0] integrate(
      input logic state,
      input logic raw,
      input integ_cnt_t cnt,
      input integ_cnt_t set_lim,
      input integ_cnt_t clr_lim
   );
      integ_cnt_t nxt;
      integ_cnt_t lim;
      lim = state ? clr_lim : set_lim;
      nxt = cnt + 15'h1;
      if (raw == state) begin
         return {1'b0, 15'h0};
      end
      if (nxt >= lim) begin
         return {1'b1, 15'h0};
      end
      return {1'b0, nxt};
   endfunction

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   state_s q;
   state_s d;

   logic tick;
   logic addr_ok;
   logic [7:0] a_idx;
   logic [7:0] rd_byte;
   logic rd_bom;
   logic rd_alarm;
   logic win40_end;
   logic win60_end;
   logic [15:0] sr_next;
   logic is_bom;
   logic is_yel;
   logic push;
   hist_entry_t push_val;
   logic short_win;
   logic [15:0] res;
   logic [2:0] alarm_old;
   logic [7:0] wb;
   logic code_set;
   logic end_set;

   assign hrdata = q.hrdata;
   assign irq_n = q.irq_n;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_comb begin
      d = q;
      tick = 1'b0;
      win40_end = 1'b0;
      win60_end = 1'b0;
      rd_bom = 1'b0;
      rd_alarm = 1'b0;
      rd_byte = 8'h00;
      push = 1'b0;
      push_val = `HIST_EMPTY;
      is_bom = 1'b0;
      is_yel = 1'b0;
      res = 16'h0000;
      alarm_old = q.alarm;
      short_win = q.bom_validation_select;
      wb = hwdata[7:0];
      code_set = 1'b0;
      end_set = 1'b0;
      a_idx = haddr[9:2];
      addr_ok = hsel && hready && htrans[1];

      // -----------------------------------------------------------
      // Millisecond timebase
      // -----------------------------------------------------------
      if (q.ms_cnt == 16'(MS_CYCLES - 1)) begin
         d.ms_cnt = 16'h0000;
         tick = 1'b1;
      end else begin
         d.ms_cnt = q.ms_cnt + 16'h0001;
      end

      // -----------------------------------------------------------
      // Per-bit window counters
      // -----------------------------------------------------------
      if (rx.oof) begin
         d.oof_seen = 1'b1;
      end
      if (rx.valid) begin
         if (rx.bit2 && rx.data && q.ones_cnt != 5'h1f) begin
            d.ones_cnt = q.ones_cnt + 5'h01;
         end
         if (rx.frame12_fbit && !rx.data && q.zeros12_cnt != 2'h3) begin
            d.zeros12_cnt = q.zeros12_cnt + 2'h1;
         end
         if (!rx.data && q.zeros60_cnt != 7'h7f) begin
            d.zeros60_cnt = q.zeros60_cnt + 7'h01;
         end
      end
      if (!rx.oof) begin
         d.oof_all = 1'b0;
      end

      // -----------------------------------------------------------
      // 40 ms and 60 ms windows
      // -----------------------------------------------------------
      if (tick) begin
         if (q.win40_cnt == 6'(`WIN_REMOTE_MS - 1)) begin
            d.win40_cnt = 6'h00;
            win40_end = 1'b1;
         end else begin
            d.win40_cnt = q.win40_cnt + 6'h01;
         end
         if (q.win60_cnt == 6'(`WIN_ALL_ONES_MS - 1)) begin
            d.win60_cnt = 6'h00;
            win60_end = 1'b1;
         end else begin
            d.win60_cnt = q.win60_cnt + 6'h01;
         end
      end
      if (win40_end) begin
         d.oof_window_flag = q.oof_seen || rx.oof;
         d.oof_seen = 1'b0;
         d.ones_cnt = 5'h00;
         d.zeros12_cnt = 2'h0;
         if (!q.esf) begin
            if (q.japan_yellow_mode) begin
               d.remote_alarm_raw =
                  q.zeros12_cnt <= 2'(`SF_J1_ZEROS_MAX);
            end else begin
               d.remote_alarm_raw =
                  q.ones_cnt <= 5'(`SF_T1_ONES_MAX);
            end
         end
      end
      if (win60_end) begin
         d.all_ones_raw = q.oof_all && rx.oof &&
            q.zeros60_cnt < 7'(`AO_ZEROS_LIMIT);
         d.oof_all = 1'b1;
         d.zeros60_cnt = 7'h00;
      end

      // -----------------------------------------------------------
      // ESF data link codewords
      // -----------------------------------------------------------
      sr_next = {q.dl_sr[14:0], rx.data};
      if (rx.valid && rx.dl_bit && q.esf) begin
         d.dl_sr = sr_next;
         d.dl_cnt = q.dl_cnt + 4'h1;
         is_yel = sr_next == (q.japan_yellow_mode ?
            `ESF_YEL_J1 : `ESF_YEL_T1);
         is_bom = sr_next[15:8] == 8'hff && !sr_next[7] && !sr_next[0];
         if (is_yel) begin
            push = 1'b1;
            push_val = `HIST_YELLOW;
         end else if (is_bom) begin
            push = 1'b1;
            push_val = {1'b0, sr_next[6:1]};
         end else if (q.dl_cnt == 4'hf) begin
            push = 1'b1;
         end
         if (push) begin
            d.dl_cnt = 4'h0;
         end
      end
      if (push) begin
         d.hist = {q.hist[8:0], push_val};
      end
      if (q.esf) begin
         d.remote_alarm_raw =
            validated(q.hist, `HIST_YELLOW, short_win);
      end

      // -----------------------------------------------------------
      // Message validation
      // -----------------------------------------------------------
      if (q.hist[0] != `HIST_EMPTY && q.hist[0] != `HIST_YELLOW &&
          q.hist[0][5:0] != `BOM_NONE && q.hist[0][5:0] != q.bom_code &&
          validated(q.hist, q.hist[0], short_win)) begin
         d.bom_code = q.hist[0][5:0];
         d.bom_code_flag = 1'b1;
         code_set = 1'b1;
      end else if (q.bom_code != `BOM_NONE &&
          !validated(q.hist, {1'b0, q.bom_code}, short_win)) begin
         d.bom_code = `BOM_NONE;
         d.bom_end_flag = 1'b1;
         end_set = 1'b1;
      end

      // -----------------------------------------------------------
      // Alarm integration
      // -----------------------------------------------------------
      if (tick) begin
         res = integrate(q.alarm[`BIT_REMOTE], q.remote_alarm_raw,
            q.integ[`BIT_REMOTE], 15'(`RA_SET_MS),
            15'(`RA_CLR_MS));
         d.integ[`BIT_REMOTE] = res[14:0];
         d.alarm[`BIT_REMOTE] = q.alarm[`BIT_REMOTE] ^ res[15];
         res = integrate(q.alarm[`BIT_CARRIER_FAIL], q.oof_window_flag,
            q.integ[`BIT_CARRIER_FAIL], 15'(`CF_SET_MS),
            q.fast_alarm_clear ? 15'(`CF_FAST_CLR_MS) :
            15'(`CF_CLR_MS));
         d.integ[`BIT_CARRIER_FAIL] = res[14:0];
         d.alarm[`BIT_CARRIER_FAIL] =
            q.alarm[`BIT_CARRIER_FAIL] ^ res[15];
         res = integrate(q.alarm[`BIT_ALL_ONES], q.all_ones_raw,
            q.integ[`BIT_ALL_ONES], 15'(`AO_SET_MS),
            q.fast_alarm_clear ? 15'(`AO_FAST_CLR_MS) :
            15'(`AO_CLR_MS));
         d.integ[`BIT_ALL_ONES] = res[14:0];
         d.alarm[`BIT_ALL_ONES] = q.alarm[`BIT_ALL_ONES] ^ res[15];
      end

      // -----------------------------------------------------------
      // Bus read: capture data, clear read-sensitive flags
      // -----------------------------------------------------------
      if (addr_ok && !hwrite) begin
         unique case (a_idx)
            `IDX_BOM_RECEIVE_CONTROL: begin
               rd_byte = {5'h00, q.bom_end_irq_en,
                  q.bom_validation_select, q.bom_code_irq_en};
            end
            `IDX_BOM_CODE_STATUS: begin
               rd_byte = {q.bom_end_flag, q.bom_code_flag, q.bom_code};
               rd_bom = 1'b1;
            end
            `IDX_ALARM_DETECT_CONFIG: begin
               rd_byte = {2'h0, q.japan_yellow_mode, q.esf, 4'h0};
            end
            `IDX_ALARM_IRQ_ENABLE: begin
               rd_byte = {3'h0, q.fast_alarm_clear, 1'b0, q.irq_en};
            end
            `IDX_ALARM_IRQ_STATUS: begin
               rd_byte = {2'h0, q.chg, q.alarm};
               rd_alarm = 1'b1;
            end
            `IDX_ALARM_RAW_STATUS: begin
               rd_byte = {5'h00, q.oof_window_flag, q.remote_alarm_raw,
                  q.all_ones_raw};
            end
            default: begin
               rd_byte = 8'h00;
            end
         endcase
      end
      if (addr_ok && !hwrite) begin
         d.hrdata = {24'h000000, rd_byte};
      end

      // Set wins over a read clear in the same cycle
      if (rd_bom) begin
         d.bom_end_flag = end_set;
         d.bom_code_flag = code_set;
      end
      if (rd_alarm) begin
         d.chg = 3'h0;
      end
      d.chg = d.chg | (d.alarm ^ alarm_old);

      // -----------------------------------------------------------
      // Bus write: data phase follows the captured address
      // -----------------------------------------------------------
      d.wr_pend = addr_ok && hwrite;
      if (addr_ok && hwrite) begin
         d.wr_idx = a_idx;
      end
      if (q.wr_pend) begin
         unique case (q.wr_idx)
            `IDX_BOM_RECEIVE_CONTROL: begin
               d.bom_end_irq_en = wb[`BIT_BOM_END_IRQ_EN];
               d.bom_validation_select = wb[`BIT_BOM_VAL_SEL];
               d.bom_code_irq_en = wb[`BIT_BOM_CODE_IRQ_EN];
            end
            `IDX_ALARM_DETECT_CONFIG: begin
               d.japan_yellow_mode = wb[`BIT_J1];
               d.esf = wb[`BIT_ESF];
            end
            `IDX_ALARM_IRQ_ENABLE: begin
               d.fast_alarm_clear = wb[`BIT_FAST_CLEAR];
               d.irq_en = wb[2:0];
            end
            default: begin
            end
         endcase
      end

      // -----------------------------------------------------------
      // Interrupt output
      // -----------------------------------------------------------
      d.irq_n = !((d.bom_code_flag && d.bom_code_irq_en) ||
         (d.bom_end_flag && d.bom_end_irq_en) ||
         |(d.chg & d.irq_en));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.bom_code <= `BOM_NONE;
         q.hist <= {10{`HIST_EMPTY}};
         q.oof_all <= 1'b1;
         q.irq_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

endmodule

// >>> test/rx_source.sv
// Purpose: Framed receive stream source facing the detector
// Assumes: One bit per cycle, bit roles fixed by position
// Notes: Odd bits are bit 2 slots, every fourth bit is an F-bit
`timescale 1ns/1ps
module rx_source
   import t1_alarm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic oof_in,
   input wire logic ones,
   input wire logic [15:0] word,
   output rx_stream_s rx
);
   // ------------------------------------------------------------
   // Stream generator
   // ------------------------------------------------------------
   logic [5:0] pos_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_q <= 6'h0;
         rx <= '0;
      end else begin
         pos_q <= pos_q + 6'h1;
         rx.valid <= 1'b1;
         rx.oof <= oof_in;
         rx.bit2 <= pos_q[0];
         rx.frame12_fbit <= (pos_q[1:0] == 2'h0);
         rx.dl_bit <= (pos_q[1:0] == 2'h0);
         // F-bits carry the data-link word, first bit first
         rx.data <= (pos_q[1:0] == 2'h0) ? word[~pos_q[5:2]] : ones;
      end
   end
endmodule

// >>> test/t1_alarm_and_bom_detector_checker.sv
// Purpose: Port-level checks for the alarm and message detector
// Assumes: Zero wait state slave, out-of-sync level seen on rx
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`include "t1_alarm_params.svh"
module t1_alarm_and_bom_detector_checker
   import t1_alarm_pkg::*;
#(
   parameter int MS_CYCLES = 40000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire rx_stream_s rx,
   input wire logic irq_n
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   localparam int WIN2 = 84 * MS_CYCLES;
   localparam int CF_HI = 2650 * MS_CYCLES;
   localparam int AO_LO = 130 * MS_CYCLES;
   int hi_cnt;
   int lo_cnt;
   logic take;
   logic rd;
   logic [7:0] idx;
   assign take = hsel && hready && htrans[1];
   assign rd = take && !hwrite;
   assign idx = haddr[9:2];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_cnt <= 0;
         lo_cnt <= 0;
      end else begin
         hi_cnt <= rx.oof ? hi_cnt + 1 : 0;
         lo_cnt <= rx.oof ? 0 : lo_cnt + 1;
      end
   end
   function automatic logic [7:0] rsv_mask(input logic [7:0] i);
      case (i)
         `IDX_BOM_RECEIVE_CONTROL: rsv_mask = 8'h07;
         `IDX_BOM_CODE_STATUS: rsv_mask = 8'hff;
         `IDX_ALARM_DETECT_CONFIG: rsv_mask = 8'h30;
         `IDX_ALARM_IRQ_ENABLE: rsv_mask = 8'h17;
         `IDX_ALARM_IRQ_STATUS: rsv_mask = 8'h3f;
         `IDX_ALARM_RAW_STATUS: rsv_mask = 8'h07;
         default: rsv_mask = 8'h00;
      endcase
   endfunction
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence rd_of(logic [7:0] i);
      rd && idx == i;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("Slave stalled or answered an error");
   a_reserved_zero: assert property (rd |=> hrdata[31:8] == 24'h0 &&
      (hrdata[7:0] & ~rsv_mask($past(idx))) == 8'h0)
      else $error("Reserved or unmapped read bits not zero");
   a_rdata_hold: assert property (!rd |=> $stable(hrdata))
      else $error("Read data moved without a read");
   a_irq_release: assert property (
      $rose(irq_n) |-> $past(take) || $past(take, 2))
      else $error("Interrupt released without an access");
   a_code_none: assert property (
      rd_of(`IDX_BOM_CODE_STATUS) ##1 (hrdata[7] && !hrdata[6])
      |-> hrdata[5:0] == `BOM_NONE)
      else $error("Message end reported with a code shown");
   a_code_flag: assert property (
      rd_of(`IDX_BOM_CODE_STATUS) ##1 (hrdata[6] && !hrdata[7])
      |-> hrdata[5:0] != `BOM_NONE)
      else $error("Code flag reported with no code shown");
   a_oof_seen: assert property (
      rd && idx == `IDX_ALARM_RAW_STATUS && hi_cnt >= WIN2 |=> hrdata[2])
      else $error("Window flag low during long loss");
   a_oof_quiet: assert property (
      rd && idx == `IDX_ALARM_RAW_STATUS && lo_cnt >= WIN2 |=> !hrdata[2])
      else $error("Window flag high with no loss");
   a_cf_set: assert property (
      rd && idx == `IDX_ALARM_IRQ_STATUS && hi_cnt >= CF_HI |=> hrdata[1])
      else $error("Carrier fail not set after long loss");
   a_ao_gone: assert property (
      rd && idx == `IDX_ALARM_RAW_STATUS && lo_cnt >= AO_LO |=> !hrdata[0])
      else $error("All ones raw set while in sync");
endmodule

// >>> test/t1_alarm_and_bom_detector_bench.sv
// Purpose: Self-checking bench for the alarm and message detector
// Assumes: 1 ms shortened to four clocks
// Notes: Times are checked against windows around each period
`timescale 1ns/1ps
`include "t1_alarm_params.svh"
module t1_alarm_and_bom_detector_bench;
   import t1_alarm_pkg::*;
   localparam int MS = 4;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq_n;
   logic oof_in = 1'b0;
   logic ones = 1'b1;
   logic [15:0] word = 16'hffff;
   rx_stream_s rx;
   int err_total = 0;
   int cmp_count = 0;
   int seed = 32'h2d2f5679;
   logic [31:0] d;
   logic [31:0] v;
   logic [7:0] code;
   logic [7:0] cfg_a [6] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h10, 8'h10};
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   t1_alarm_and_bom_detector #(.MS_CYCLES(MS)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rx(rx), .irq_n(irq_n));
   rx_source i_src (.hclk(hclk), .hresetn(hresetn), .oof_in(oof_in),
      .ones(ones), .word(word), .rx(rx));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task give_verdict;
      $display("Compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         give_verdict;
      end
   endtask
   task xfer(input logic wr, input logic [7:0] i, input logic [31:0] w);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, i, 2'h0};
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w;
      wait_rdy;
      d = hrdata;
   endtask
   task rd(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, i, 32'h0);
      chk(d & m, e);
   endtask
   task poll(input int lo, input int hi);
      int n;
      n = 0;
      while (irq_n !== 1'b0 && n < hi) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, n >= lo && n < hi}, 32'h1);
      if (n >= hi) give_verdict;
   endtask
   initial begin
      repeat (100000) @(posedge hclk);
      err_total++;
      give_verdict;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(8'h2a + 8'(i), 32'hff, (i == 1) ? 32'h3f : 32'h0);
      end
      chk({31'h0, irq_n}, 32'h1);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         xfer(1'b1, `IDX_BOM_RECEIVE_CONTROL, v);
         rd(`IDX_BOM_RECEIVE_CONTROL, 32'hff, v & 32'h07);
         xfer(1'b1, `IDX_ALARM_DETECT_CONFIG, v);
         rd(`IDX_ALARM_DETECT_CONFIG, 32'hff, v & 32'h30);
         xfer(1'b1, `IDX_ALARM_IRQ_ENABLE, v);
         rd(`IDX_ALARM_IRQ_ENABLE, 32'hff, v & 32'h17);
      end
      xfer(1'b1, `IDX_BOM_RECEIVE_CONTROL, 32'h0);
      xfer(1'b1, `IDX_ALARM_IRQ_ENABLE, 32'h04);
      // Remote alarm set and clear in T1 SF and T1 ESF, set only in J1 SF
      for (int r = 0; r < 6; r++) begin
         xfer(1'b1, `IDX_ALARM_DETECT_CONFIG, {24'h0, cfg_a[r]});
         ones <= (r != 0);
         word <= (r == 4) ? 16'hff00 : 16'hffff;
         poll(375 * MS, 675 * MS);
         rd(`IDX_ALARM_IRQ_STATUS, 32'hff, r[0] ? 32'h20 : 32'h24);
         rd(`IDX_ALARM_IRQ_STATUS, 32'hff, r[0] ? 32'h0 : 32'h04);
         chk({31'h0, irq_n}, 32'h1);
      end
      // Loss of sync: all ones masked, carrier fail enabled, fast clear
      xfer(1'b1, `IDX_ALARM_DETECT_CONFIG, 32'h0);
      xfer(1'b1, `IDX_ALARM_IRQ_ENABLE, 32'h12);
      oof_in <= 1'b1;
      poll(2510 * MS, 2750 * MS);
      repeat (200 * MS) @(posedge hclk);
      rd(`IDX_ALARM_IRQ_STATUS, 32'hff, 32'h1b);
      rd(`IDX_ALARM_RAW_STATUS, 32'hff, 32'h05);
      oof_in <= 1'b0;
      poll(110 * MS, 220 * MS);
      repeat (250 * MS) @(posedge hclk);
      rd(`IDX_ALARM_IRQ_STATUS, 32'hff, 32'h18);
      rd(`IDX_ALARM_RAW_STATUS, 32'hff, 32'h0);
      // Messages with short then long validation
      xfer(1'b1, `IDX_ALARM_IRQ_ENABLE, 32'h0);
      xfer(1'b1, `IDX_ALARM_DETECT_CONFIG, 32'h10);
      for (int s = 1; s >= 0; s--) begin
         v = $random(seed);
         code = {3'h0, v[4:0]} + 8'h1;
         xfer(1'b1, `IDX_BOM_RECEIVE_CONTROL, s[0] ? 32'h07 : 32'h05);
         word <= {8'hff, 1'b0, code[5:0], 1'b0};
         poll(s[0] ? 192 : 448, s[0] ? 512 : 832);
         rd(`IDX_BOM_CODE_STATUS, 32'hff, 32'h40 | code);
         rd(`IDX_BOM_CODE_STATUS, 32'hff, {24'h0, code});
         word <= 16'hffff;
         poll(0, 832);
         rd(`IDX_BOM_CODE_STATUS, 32'hff, 32'hbf);
         rd(`IDX_BOM_CODE_STATUS, 32'hff, 32'h3f);
         chk({31'h0, irq_n}, 32'h1);
      end
      give_verdict;
   end
endmodule
bind t1_alarm_and_bom_detector t1_alarm_and_bom_detector_checker
   #(.MS_CYCLES(MS_CYCLES)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .rx(rx), .irq_n(irq_n));
